// file: src/external_pin_interrupt_unit.sv
// External pin interrupt unit with AXI4-Lite register slave
// Summary of operation
// - Enabled pin toggle sets change flag
// - Pins sensed even when driven as outputs
// - Pin change seen through the two-stage synchroniser
// - Pin B sense select decode
// - Pin A sense select decode
// - Low level requests while pin low
// - Edge sense only while clock runs
// - Low level sensed from pin level
// - Vanished level gives no interrupt
// - Pins sampled before edge detection
// - Enables at bits 7,6,5 with global
// - Event flags at bits 7,6,5
// - Flags clear on acknowledge or write-one
// - Pin flag cleared under low-level sense
// - Per-pin change mask bits
// - Three separate vector requests
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "ext_irq_cfg.svh"
module external_pin_interrupt_unit
    import ext_irq_pkg::*;
#(
    parameter int ADDR_W = 12 // AXI address width
) (
    input wire logic aclk, // Clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic ext_irq_pin_a, // Dedicated interrupt pin A
    input wire logic ext_irq_pin_b, // Dedicated interrupt pin B
    input wire logic [7:0] change_watch_pins, // Pin-change inputs
    input wire logic [2:0] vector_ack, // Core taking vector b,a,change
    output irq_req_t vector_req, // Requests to vector dispatch
    output logic irq // Level interrupt, any unmasked flag
);
    // Decode needs bits 4:0 plus an upper field, and at most 12 address bits are held
    if (ADDR_W < 6 || ADDR_W > 12) begin : g_addr_w_check
        $error("ADDR_W must lie between 6 and 12");
    end

    state_t s_r; // Registered state
    state_t s_nxt; // Next state
    sense_t sense_a; // Decoded sense of pin A
    sense_t sense_b; // Decoded sense of pin B
    logic [1:0] pin_now; // Synchronised dedicated pins {b,a}
    logic [1:0] pin_evt; // Edge events {b,a}
    logic [1:0] pin_low; // Low level requests {b,a}
    logic [7:0] pc_toggle; // Per-pin toggle seen
    logic pc_evt; // Any enabled pin toggled
    logic [7:0] set_flags; // Hardware flag sets
    logic [7:0] clr_flags; // Write-one and acknowledge clears
    logic wr_fire; // Write commits this cycle
    logic [31:0] rd_val; // Read mux output
    logic rd_ok; // Read address mapped

    // Sense decode from control register
    always_comb begin
        sense_b = sense_t'(s_r.core_control_reg[`BIT_SENSE_B +: 2]);
        sense_a = sense_t'(s_r.core_control_reg[`BIT_SENSE_A +: 2]);
    end

    // Edge detection on the two-stage samples of the pins
    assign pin_now = s_r.sync2;
    always_comb begin
        pin_evt = 2'b00;
        for (int i = 0; i < 2; i++) begin
            unique case (i == 1 ? sense_b : sense_a)
                SENSE_LOW: begin
                    pin_evt[i] = 1'b0;
                end
                SENSE_ANY: begin
                    pin_evt[i] = pin_now[i] ^ s_r.pin_prev[i];
                end
                SENSE_FALL: begin
                    pin_evt[i] = s_r.pin_prev[i] & ~pin_now[i];
                end
                SENSE_RISE: begin
                    pin_evt[i] = ~s_r.pin_prev[i] & pin_now[i];
                end
            endcase
        end
    end

    // Low level requests follow the pin, never stored
    assign pin_low[1] = (sense_b == SENSE_LOW) & ~pin_now[1];
    assign pin_low[0] = (sense_a == SENSE_LOW) & ~pin_now[0];

    // Pin-change toggle per pin, gated by its mask bit
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pc
            assign pc_toggle[g] = s_r.change_pin_mask[g] & (s_r.pc_sync2[g] ^ s_r.pc_prev[g]);
        end
    endgenerate
    assign pc_evt = |pc_toggle;

    // Flag sets and clears
    always_comb begin
        set_flags = 8'h00;
        set_flags[`BIT_EN_B] = pin_evt[1];
        set_flags[`BIT_EN_A] = pin_evt[0];
        set_flags[`BIT_EN_PC] = pc_evt;
        clr_flags = 8'h00;
        if (wr_fire && s_r.awaddr == `OFS_FLAGS && s_r.wstrb[0]) begin
            clr_flags = s_r.wdata[7:0] & `MASK_FLAGS;
        end
        clr_flags[`BIT_EN_B] = clr_flags[`BIT_EN_B] | vector_ack[2];
        clr_flags[`BIT_EN_A] = clr_flags[`BIT_EN_A] | vector_ack[1];
        clr_flags[`BIT_EN_PC] = clr_flags[`BIT_EN_PC] | vector_ack[0];
    end

    assign wr_fire = s_r.aw_got & s_r.w_got & (s_r.wr_state == WR_IDLE);

    // Read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[4:0])
            5'(`OFS_SENSE): begin
                rd_val[7:0] = s_r.core_control_reg;
            end
            5'(`OFS_ENABLE): begin
                rd_val[7:0] = s_r.irq_enable_reg;
            end
            5'(`OFS_FLAGS): begin
                rd_val[7:0] = s_r.irq_flag_reg;
            end
            5'(`OFS_PCMASK): begin
                rd_val[7:0] = s_r.change_pin_mask;
            end
            5'(`OFS_GLOBAL): begin
                rd_val[0] = s_r.global_en;
            end
            5'(`OFS_PINS): begin
                rd_val[9:0] = {s_r.sync2, s_r.pc_sync2};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
        if (s_axi_araddr[ADDR_W-1:5] != '0) begin
            rd_ok = 1'b0;
            rd_val = 32'h0000_0000;
        end
    end

    // Next state
    always_comb begin
        s_nxt = s_r;
        // Pins are sampled regardless of direction
        s_nxt.sync1 = {ext_irq_pin_b, ext_irq_pin_a};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.pin_prev = s_r.sync2;
        s_nxt.pc_sync1 = change_watch_pins;
        s_nxt.pc_sync2 = s_r.pc_sync1;
        s_nxt.pc_prev = s_r.pc_sync2;
        // Set wins over clear
        s_nxt.irq_flag_reg = ((s_r.irq_flag_reg & ~clr_flags) | set_flags) & `MASK_FLAGS;
        if (sense_b == SENSE_LOW) begin
            s_nxt.irq_flag_reg[`BIT_EN_B] = 1'b0;
        end
        if (sense_a == SENSE_LOW) begin
            s_nxt.irq_flag_reg[`BIT_EN_A] = 1'b0;
        end
        // Write channel capture
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = 12'(s_axi_awaddr);
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        unique case (s_r.wr_state)
            WR_IDLE: begin
                if (wr_fire) begin
                    s_nxt.wr_state = WR_RESP;
                    s_nxt.bresp = 2'b00;
                    if (s_r.wstrb[0]) begin
                        unique case (s_r.awaddr)
                            `OFS_SENSE: begin
                                s_nxt.core_control_reg = s_r.wdata[7:0];
                            end
                            `OFS_ENABLE: begin
                                s_nxt.irq_enable_reg = s_r.wdata[7:0] & `MASK_FLAGS;
                            end
                            `OFS_FLAGS: begin
                                s_nxt.bresp = 2'b00;
                            end
                            `OFS_PCMASK: begin
                                s_nxt.change_pin_mask = s_r.wdata[7:0];
                            end
                            `OFS_GLOBAL: begin
                                s_nxt.global_en = s_r.wdata[0];
                            end
                            `OFS_PINS: begin
                                s_nxt.bresp = 2'b00;
                            end
                            default: begin
                                s_nxt.bresp = 2'b10;
                            end
                        endcase
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    s_nxt.wr_state = WR_IDLE;
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                end
            end
        endcase
        unique case (s_r.rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    s_nxt.rd_state = RD_DATA;
                    s_nxt.rdata = rd_val;
                    s_nxt.rresp = rd_ok ? 2'b00 : 2'b10;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    s_nxt.rd_state = RD_IDLE;
                end
            end
        endcase
        // Vector requests: flag or low level, enable and global enable
        s_nxt.req.pin_b = s_r.global_en & s_r.irq_enable_reg[`BIT_EN_B]
            & (s_nxt.irq_flag_reg[`BIT_EN_B] | pin_low[1]);
        s_nxt.req.pin_a = s_r.global_en & s_r.irq_enable_reg[`BIT_EN_A]
            & (s_nxt.irq_flag_reg[`BIT_EN_A] | pin_low[0]);
        s_nxt.req.change = s_r.global_en & s_r.irq_enable_reg[`BIT_EN_PC]
            & s_nxt.irq_flag_reg[`BIT_EN_PC];
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.wr_state <= WR_IDLE;
            s_r.rd_state <= RD_IDLE;
            s_r.sync1 <= 2'b11;
            s_r.sync2 <= 2'b11;
            s_r.pin_prev <= 2'b11;
            // Change pins idle high too, so no false toggle follows reset
            s_r.pc_sync1 <= 8'hFF;
            s_r.pc_sync2 <= 8'hFF;
            s_r.pc_prev <= 8'hFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign s_axi_awready = ~s_r.aw_got;
    assign s_axi_wready = ~s_r.w_got;
    assign s_axi_bvalid = (s_r.wr_state == WR_RESP);
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = (s_r.rd_state == RD_IDLE);
    assign s_axi_rvalid = (s_r.rd_state == RD_DATA);
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign vector_req = s_r.req;
    assign irq = |(s_r.irq_flag_reg & s_r.irq_enable_reg);

    // Any-change on pin A sets its flag at the edge after the synchronised change
    property p_any_a;
        @(posedge aclk) disable iff (!aresetn)
        (sense_a == SENSE_ANY && $changed(pin_now[0]) && $stable(s_r.core_control_reg))
        |=> s_r.irq_flag_reg[`BIT_EN_A];
    endproperty
    a_any_a: assert property (p_any_a) else $error("pin A change did not set flag");

    property p_fall_b;
        @(posedge aclk) disable iff (!aresetn)
        (sense_b == SENSE_FALL && $fell(pin_now[1]) && $stable(s_r.core_control_reg))
        |=> s_r.irq_flag_reg[`BIT_EN_B];
    endproperty
    a_fall_b: assert property (p_fall_b) else $error("pin B fall did not set flag");

    // Rise on pin A sets its flag at the next edge
    property p_rise_a;
        @(posedge aclk) disable iff (!aresetn)
        (sense_a == SENSE_RISE && $rose(pin_now[0])) |=> s_r.irq_flag_reg[`BIT_EN_A];
    endproperty
    a_rise_a: assert property (p_rise_a) else $error("pin A rise did not set flag");

    property p_rise_b_only;
        @(posedge aclk) disable iff (!aresetn)
        (sense_b == SENSE_RISE && !s_r.irq_flag_reg[`BIT_EN_B] && !$rose(pin_now[1]))
        |=> !s_r.irq_flag_reg[`BIT_EN_B] || $past(pin_evt[1]);
    endproperty
    a_rise_b_only: assert property (p_rise_b_only) else $error("pin B flag set without rise");

    property p_low_clear;
        @(posedge aclk) disable iff (!aresetn)
        $past(sense_a == SENSE_LOW) |-> !s_r.irq_flag_reg[`BIT_EN_A];
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("pin A flag set under low sense");

    // Low-level sense keeps the pin B flag clear
    property p_low_clear_b;
        @(posedge aclk) disable iff (!aresetn)
        $past(sense_b == SENSE_LOW) |-> !s_r.irq_flag_reg[`BIT_EN_B];
    endproperty
    a_low_clear_b: assert property (p_low_clear_b) else $error("pin B flag set under low sense");

    property p_low_req;
        @(posedge aclk) disable iff (!aresetn)
        (pin_low[0] && s_r.global_en && s_r.irq_enable_reg[`BIT_EN_A]) |=> vector_req.pin_a;
    endproperty
    a_low_req: assert property (p_low_req) else $error("low level did not request");

    // Pin B held low requests its vector while enabled
    property p_low_req_b;
        @(posedge aclk) disable iff (!aresetn)
        (pin_low[1] && s_r.global_en && s_r.irq_enable_reg[`BIT_EN_B]) |=> vector_req.pin_b;
    endproperty
    a_low_req_b: assert property (p_low_req_b) else $error("pin B low level did not request");

    property p_pc_set;
        @(posedge aclk) disable iff (!aresetn)
        (pc_evt) |=> s_r.irq_flag_reg[`BIT_EN_PC];
    endproperty
    a_pc_set: assert property (p_pc_set) else $error("pin change flag not set");

    property p_pc_mask;
        @(posedge aclk) disable iff (!aresetn)
        (s_r.change_pin_mask == 8'h00 && !s_r.irq_flag_reg[`BIT_EN_PC]) |=> !s_r.irq_flag_reg[`BIT_EN_PC];
    endproperty
    a_pc_mask: assert property (p_pc_mask) else $error("masked pins set change flag");

    property p_ack_clear;
        @(posedge aclk) disable iff (!aresetn)
        (vector_ack[0] && !pc_evt) |=> !s_r.irq_flag_reg[`BIT_EN_PC];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag");

    // Write-one clears the change flag unless a toggle lands in the same cycle
    property p_w1c_pc;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && s_r.awaddr == `OFS_FLAGS && s_r.wstrb[0] && s_r.wdata[`BIT_EN_PC] && !pc_evt)
        |=> !s_r.irq_flag_reg[`BIT_EN_PC];
    endproperty
    a_w1c_pc: assert property (p_w1c_pc) else $error("write-one did not clear change flag");

    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
        !s_r.global_en |=> !vector_req.change && !vector_req.pin_a && !vector_req.pin_b;
    endproperty
    a_gate: assert property (p_gate) else $error("request without global enable");
endmodule

// file: src/ext_irq_cfg.svh
// Register offsets, field positions and reset values of the external pin interrupt unit
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH
`define OFS_SENSE 12'h000
`define OFS_ENABLE 12'h004
`define OFS_FLAGS 12'h008
`define OFS_PCMASK 12'h00C
`define OFS_GLOBAL 12'h010
`define OFS_PINS 12'h014
`define BIT_EN_B 7
`define BIT_EN_A 6
`define BIT_EN_PC 5
`define BIT_SENSE_B 2
`define BIT_SENSE_A 0
`define RST_REG8 8'h00
`define MASK_FLAGS 8'hE0
`endif

// file: src/ext_irq_pkg.sv
// Types of the external pin interrupt unit
package ext_irq_pkg;
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_t;
    typedef enum {
        WR_IDLE,
        WR_RESP
    } wr_state_t;
    typedef enum {
        RD_IDLE,
        RD_DATA
    } rd_state_t;
    // Request lines to the core vector dispatch
    typedef struct packed {
        logic pin_b;
        logic pin_a;
        logic change;
    } irq_req_t;
    // All state of the unit
    typedef struct packed {
        logic [7:0] core_control_reg;
        logic [7:0] irq_enable_reg;
        logic [7:0] irq_flag_reg;
        logic [7:0] change_pin_mask;
        logic global_en;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] pin_prev;
        logic [7:0] pc_sync1;
        logic [7:0] pc_sync2;
        logic [7:0] pc_prev;
        wr_state_t wr_state;
        rd_state_t rd_state;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        irq_req_t req;
    } state_t;
endpackage

// file: tb/pin_source_model.sv
// Behavioural external sources that drive the interrupt and pin-change inputs
`timescale 1ns/10ps
module pin_source_model (
    input wire logic aclk, // Clock
    input wire logic a_lvl, // Level wanted on pin A
    input wire logic b_lvl, // Level wanted on pin B
    input wire logic [7:0] pc_lvl, // Levels wanted on change pins
    output logic pin_a, // Pin A
    output logic pin_b, // Pin B
    output logic [7:0] pins // Change pins
);
    // Launch levels after an edge and hold them for many cycles
    // The part's own output driver can stand in for this source as well
    always_ff @(posedge aclk) begin
        pin_a <= a_lvl;
        pin_b <= b_lvl;
        pins <= pc_lvl;
    end
endmodule

// file: tb/external_pin_interrupt_unit_tb.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
`include "ext_irq_cfg.svh"
module external_pin_interrupt_unit_tb;
    import ext_irq_pkg::*;
    logic aclk, aresetn; // Clock and reset
    logic [11:0] s_axi_awaddr, s_axi_araddr; // Addresses
    logic [31:0] s_axi_wdata, s_axi_rdata; // Data
    logic [3:0] s_axi_wstrb; // Strobes
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write handshakes
    logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // More handshakes
    logic s_axi_rvalid, s_axi_rready; // Read handshake
    logic ext_irq_pin_a, ext_irq_pin_b, irq; // Pins and interrupt
    logic [7:0] change_watch_pins, pc_lvl; // Change pins
    logic [2:0] vector_ack; // Vector taken pulses
    irq_req_t vector_req; // Vector requests
    logic a_lvl, b_lvl; // Wanted pin levels
    int errors, tests_run; // Counters
    logic [31:0] d, bitv; // Scratch
    logic [1:0] r; // Scratch response
    logic [1:0] wresp; // Last write response
    external_pin_interrupt_unit u_external_pin_interrupt_unit (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b), .change_watch_pins(change_watch_pins),
        .vector_ack(vector_ack), .vector_req(vector_req), .irq(irq));
    pin_source_model u_pin_source_model (.aclk(aclk), .a_lvl(a_lvl), .b_lvl(b_lvl), .pc_lvl(pc_lvl),
        .pin_a(ext_irq_pin_a), .pin_b(ext_irq_pin_b), .pins(change_watch_pins));
    // 250 MHz clock
    always #2 aclk = ~aclk;
    // Verdict and end of run
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Value comparison
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Single bit comparison
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    // Idle cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Bounded wait ran out
    task automatic hang();
        errors++;
        $display("mismatch at %0t: bus timeout", $time);
        complete_run();
    endtask
    // Write one word; handshakes judged at the settled half of the cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw, tb, done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            wresp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tb) begin
                s_axi_bready <= 0;
                done = 1;
            end
        end
        if (!done) hang();
    endtask
    // Read one word with its response
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            if (done) s_axi_rready <= 0;
        end
        if (!done) hang();
    endtask
    // Read and compare data
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk_val(d, exp);
    endtask
    // One-cycle vector taken pulse from the core
    task automatic pulse_ack(input logic [2:0] v);
        @(posedge aclk);
        vector_ack <= v;
        @(posedge aclk);
        vector_ack <= 3'b000;
    endtask
    // Move one dedicated pin and let it cross the synchroniser
    task automatic drive(input int p, input logic v);
        @(posedge aclk);
        if (p == 1) b_lvl <= v;
        else a_lvl <= v;
        wait_cyc(6);
    endtask
    // Main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, vector_ack} = '0;
        {errors, tests_run} = '0;
        a_lvl = 1;
        b_lvl = 1;
        pc_lvl = 8'hFF;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        // Reset values and unmapped place
        for (int i = 0; i < 4; i++) rd_chk(12'(i * 4), 32'h0000_0000);
        rd(12'h020, d, r);
        chk_val(32'(r), 32'h0000_0002);
        rd_chk(`OFS_PINS, 32'h0000_03FF);
        wr(12'h028, 32'h0000_00E0);
        chk_val(32'(wresp), 32'h0000_0002);
        $display("test reset done");
        // Edge and any-change sense on both pins
        wr(`OFS_ENABLE, 32'h0000_00E0);
        wr(`OFS_GLOBAL, 32'h0000_0001);
        chk_val(32'(wresp), 32'h0000_0000);
        rd_chk(`OFS_GLOBAL, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            bitv = (p == 1) ? 32'h0000_0080 : 32'h0000_0040;
            for (int m = 1; m < 4; m++) begin
                wr(`OFS_SENSE, 32'(m) << (p * 2));
                wr(`OFS_FLAGS, 32'h0000_00E0);
                drive(p, 0);
                rd_chk(`OFS_FLAGS, (m != SENSE_RISE) ? bitv : 32'h0);
                chk_bit(irq, m != SENSE_RISE);
                chk_bit((p == 1) ? vector_req.pin_b : vector_req.pin_a, m != SENSE_RISE);
                wr(`OFS_FLAGS, 32'h0000_00E0);
                drive(p, 1);
                rd_chk(`OFS_FLAGS, (m != SENSE_FALL) ? bitv : 32'h0);
                pulse_ack((p == 1) ? 3'b100 : 3'b010);
                rd_chk(`OFS_FLAGS, 32'h0000_0000);
                wr(`OFS_FLAGS, 32'h0000_00E0);
                wait_cyc(2);
                chk_bit(irq, 0);
            end
        end
        $display("test edges done");
        // Low-level sense on pin A, then on pin B
        wr(`OFS_SENSE, 32'h0000_0000);
        drive(0, 0);
        chk_bit(vector_req.pin_a, 1);
        rd_chk(`OFS_FLAGS, 32'h0000_0000);
        chk_bit(irq, 0);
        wr(`OFS_GLOBAL, 32'h0000_0000);
        wait_cyc(2);
        chk_bit(vector_req.pin_a, 0);
        wr(`OFS_GLOBAL, 32'h0000_0001);
        wait_cyc(2);
        chk_bit(vector_req.pin_a, 1);
        drive(0, 1);
        chk_bit(vector_req.pin_a, 0);
        drive(1, 0);
        chk_bit(vector_req.pin_b, 1);
        rd_chk(`OFS_FLAGS, 32'h0000_0000);
        drive(1, 1);
        chk_bit(vector_req.pin_b, 0);
        $display("test level done");
        // Pin change with per-pin mask
        wr(`OFS_PCMASK, 32'h0000_0008);
        rd_chk(`OFS_PCMASK, 32'h0000_0008);
        @(posedge aclk);
        pc_lvl <= 8'hFB;
        wait_cyc(6);
        rd_chk(`OFS_FLAGS, 32'h0000_0000);
        @(posedge aclk);
        pc_lvl <= 8'hF3;
        wait_cyc(6);
        rd_chk(`OFS_FLAGS, 32'h0000_0020);
        chk_bit(vector_req.change, 1);
        wr(`OFS_ENABLE, 32'h0000_00C0);
        wait_cyc(2);
        chk_bit(irq, 0);
        chk_bit(vector_req.change, 0);
        wr(`OFS_ENABLE, 32'h0000_00E0);
        wait_cyc(2);
        chk_bit(irq, 1);
        @(posedge aclk);
        vector_ack <= 3'b001;
        @(posedge aclk);
        vector_ack <= 3'b000;
        wait_cyc(2);
        rd_chk(`OFS_FLAGS, 32'h0000_0000);
        chk_bit(vector_req.change, 0);
        $display("test change done");
        complete_run();
    end
endmodule
